// ### core/ref_qualify_map.svh
// register offsets, field positions, reset values and timing figures
// assumes: included by bare name from files under core/ and test/
`ifndef REF_QUALIFY_MAP_SVH
`define REF_QUALIFY_MAP_SVH

// ----------------------------------------
// clock and timing
// ----------------------------------------
`define MCLK_MHZ      25
`define MCLK_NS       40
`define DSQ_T0_US     2500000
`define DSQ_T1_US     1250
`define DSQ_T2_US     25000
`define DSQ_T3_US     50000
`define PW0_NS        40
`define PW1_NS        80
`define PW2_NS        160
`define PW3_NS        320

// ----------------------------------------
// register word offsets
// ----------------------------------------
`define REG_CTRL      4'h0
`define REG_SEL       4'h1
`define REG_TIMER     4'h2
`define REG_MASK      4'h3
`define REG_GPIO      4'h4
`define REG_FPER      4'h5
`define REG_CHALF     4'h6
`define REG_STATUS    4'h7
`define REG_ACNT      4'h8

// ----------------------------------------
// field positions
// ----------------------------------------
`define CTRL_EN       0
`define CTRL_SYNC     1
`define CTRL_FALL     2
`define CTRL_PW       4
`define SEL_FRAME     0
`define SEL_CLK       4
`define SEL_ACT       8
`define TIMER_DSQ     0
`define TIMER_QUAL    2
`define MASK_ACT      0
`define MASK_LOS      8
`define MASK_FREQ     16
`define GPIO_EN       7
`define STAT_QUAL     8
`define STAT_GDSQ     16
`define STAT_OSC      24

// ----------------------------------------
// reset values
// ----------------------------------------
`define FPER_RST      24'h0061a8
`define CHALF_RST     16'h0001

`endif

// ### core/ref_qualify_pkg.sv
// types shared by the reference qualification block
// assumes: compiled before every module under core/
package ref_qualify_pkg;
   typedef enum logic [1:0] {QS_QUALIFIED, QS_DSQ_WAIT, QS_DISQUALIFIED, QS_QUAL_WAIT} qual_state_t;
   typedef enum logic {AL_IDLE, AL_ARMED} align_state_t;
   typedef logic [31:0] word_t;
endpackage

// ### core/ref_qual_timer.sv
// per-reference disqualification and qualification timer
// assumes: alarm is already masked and on the mclk domain
`timescale 1ns/100ps
`default_nettype none
module ref_qual_timer (
   input  wire logic                  mclk,
   input  wire logic                  reset_n,
   input  wire logic                  alarm,
   input  wire ref_qualify_pkg::word_t dsqCycles,
   input  wire logic [1:0]            qualSel,
   output logic                       qualified
);
   import ref_qualify_pkg::*;

   typedef struct packed {
      qual_state_t st;
      word_t       cnt;
      logic        qualified;
   } state_t;

   state_t s;
   state_t next_s;
   word_t  qualLimit;

   // ----------------------------------------
   // qualification period in disqualify periods
   // ----------------------------------------
   always_comb begin
      case (qualSel)
         2'h0:    qualLimit = dsqCycles << 2;
         2'h1:    qualLimit = dsqCycles << 1;
         2'h2:    qualLimit = dsqCycles << 3;
         default: qualLimit = dsqCycles << 4;
      endcase
   end

   // ----------------------------------------
   // state update
   // ----------------------------------------
   always_comb begin
      next_s = s;
      case (s.st)
         QS_QUALIFIED: begin
            if (alarm) begin
               next_s.st  = QS_DSQ_WAIT;
               next_s.cnt = 32'h1;
            end
         end
         QS_DSQ_WAIT: begin
            if (!alarm) begin
               next_s.st  = QS_QUALIFIED;
               next_s.cnt = '0;
            end else if (s.cnt + 32'h1 >= dsqCycles) begin
               next_s.st        = QS_DISQUALIFIED;
               next_s.qualified = 1'b0;
               next_s.cnt       = '0;
            end else begin
               next_s.cnt = s.cnt + 32'h1;
            end
         end
         QS_DISQUALIFIED: begin
            if (!alarm) begin
               next_s.st  = QS_QUAL_WAIT;
               next_s.cnt = 32'h1;
            end
         end
         QS_QUAL_WAIT: begin
            if (alarm) begin
               next_s.st  = QS_DISQUALIFIED;
               next_s.cnt = '0;
            end else if (s.cnt + 32'h1 >= qualLimit) begin
               next_s.st        = QS_QUALIFIED;
               next_s.qualified = 1'b1;
               next_s.cnt       = '0;
            end else begin
               next_s.cnt = s.cnt + 32'h1;
            end
         end
         default: next_s.st = QS_DISQUALIFIED;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         s.st        <= QS_QUAL_WAIT;
         s.cnt       <= '0;
         s.qualified <= 1'b0;
      end else begin
         s <= next_s;
      end
   end

   assign qualified = s.qualified;

   a_disq_needs_alarm: assert property (@(posedge mclk) disable iff (!reset_n)
      $fell(qualified) |-> $past(alarm) && $past(s.st) == QS_DSQ_WAIT)
      else $error("reference disqualified without a held alarm");
   a_qual_needs_clear: assert property (@(posedge mclk) disable iff (!reset_n)
      $rose(qualified) |-> !$past(alarm) && $past(s.st) == QS_QUAL_WAIT)
      else $error("reference requalified while alarmed");
endmodule
`default_nettype wire

// ### core/ref_qualify_frame_sync_align.sv
// reference validity, gpio disqualify, switchover and frame or sync alignment
// assumes: monitor alarms arrive on mclk; reference and gpio pins are asynchronous
`timescale 1ns/100ps
`default_nettype none
`include "ref_qualify_map.svh"

module ref_qualify_frame_sync_align #(
   parameter int NUM_REFS  = 8,
   parameter int NUM_GPIO  = 4,
   parameter int DSQ_CYC0  = `DSQ_T0_US * `MCLK_MHZ,
   parameter int DSQ_CYC1  = `DSQ_T1_US * `MCLK_MHZ,
   parameter int DSQ_CYC2  = `DSQ_T2_US * `MCLK_MHZ,
   parameter int DSQ_CYC3  = `DSQ_T3_US * `MCLK_MHZ
) (
   input  wire logic                   mclk,
   input  wire logic                   reset_n,
   input  wire logic [3:0]             address,
   input  wire ref_qualify_pkg::word_t writeData,
   input  wire logic                   writeStrobe,
   input  wire logic                   readStrobe,
   output ref_qualify_pkg::word_t      readData,
   input  wire logic [NUM_REFS-1:0]    actAlarm,
   input  wire logic [NUM_REFS-1:0]    losAlarm,
   input  wire logic [NUM_REFS-1:0]    freqAlarm,
   input  wire logic [NUM_GPIO-1:0]    gpioPin,
   input  wire logic [NUM_REFS-1:0]    refPin,
   output logic [NUM_REFS-1:0]         refValid,
   output logic                        switchReq,
   output logic [2:0]                  switchTarget,
   output logic                        oscRefSuspect,
   output logic                        alignPulse,
   output logic                        frameOut,
   output logic                        clkOut
);
   import ref_qualify_pkg::*;

   localparam int PW0 = (`PW0_NS + `MCLK_NS - 1) / `MCLK_NS;
   localparam int PW1 = (`PW1_NS + `MCLK_NS - 1) / `MCLK_NS;
   localparam int PW2 = (`PW2_NS + `MCLK_NS - 1) / `MCLK_NS;
   localparam int PW3 = (`PW3_NS + `MCLK_NS - 1) / `MCLK_NS;

   typedef struct packed {
      logic [NUM_GPIO-1:0] gpioS1;
      logic [NUM_GPIO-1:0] gpioS2;
      logic [NUM_REFS-1:0] pinS1;
      logic [NUM_REFS-1:0] pinS2;
      logic [NUM_REFS-1:0] pinPrev;
      word_t               ctrl;
      word_t               sel;
      word_t               timer;
      word_t               mask;
      word_t               gpioCfg;
      logic [23:0]         framePer;
      logic [15:0]         clkHalf;
      logic [NUM_REFS-1:0] gpioDsq;
      logic [NUM_REFS-1:0] valid;
      logic                switchReq;
      logic [2:0]          switchTarget;
      logic                oscSuspect;
      align_state_t        alState;
      logic                alignPulse;
      logic [23:0]         frameCnt;
      logic [7:0]          pwCnt;
      logic                frameOut;
      logic [15:0]         clkCnt;
      logic                clkOut;
      logic [15:0]         alignCnt;
      word_t               readData;
   } state_t;

   state_t              s;
   state_t              next_s;
   logic [NUM_REFS-1:0] qualified;
   logic [NUM_REFS-1:0] timedAlarm;
   logic [NUM_REFS-1:0] gpioDsqNow;
   word_t               dsqCycles;

   // ----------------------------------------
   // disqualify time select, gpio to reference disqualify map and per-reference timers
   // ----------------------------------------
   always_comb begin
      case (s.timer[`TIMER_DSQ +: 2])
         2'h0:    dsqCycles = word_t'(DSQ_CYC0);
         2'h1:    dsqCycles = word_t'(DSQ_CYC1);
         2'h2:    dsqCycles = word_t'(DSQ_CYC2);
         default: dsqCycles = word_t'(DSQ_CYC3);
      endcase
   end

   genvar r;
   generate
      for (r = 0; r < NUM_REFS; r++) begin : g_ref
         logic [NUM_GPIO-1:0] hit;
         for (genvar g = 0; g < NUM_GPIO; g++) begin : g_gpio
            assign hit[g] = s.gpioCfg[8*g + `GPIO_EN] && s.gpioS2[g]
                         && s.gpioCfg[8*g +: 3] == 3'(r);
         end
         assign gpioDsqNow[r] = |hit;
         assign timedAlarm[r] = (actAlarm[r] && !s.mask[`MASK_ACT + r])
                             || (losAlarm[r] && !s.mask[`MASK_LOS + r]);
         ref_qual_timer u_timer (
            .mclk      (mclk),
            .reset_n   (reset_n),
            .alarm     (timedAlarm[r]),
            .dsqCycles (dsqCycles),
            .qualSel   (s.timer[`TIMER_QUAL +: 2]),
            .qualified (qualified[r])
         );
      end
   endgenerate

   // ----------------------------------------
   // state update
   // ----------------------------------------
   always_comb begin
      logic [2:0]  act;
      logic [2:0]  frIdx;
      logic [2:0]  ckIdx;
      logic        frEdge;
      logic        ckRise;
      logic        found;
      logic [7:0]  pw;
      logic        doAlign;
      act     = '0;
      frIdx   = '0;
      ckIdx   = '0;
      frEdge  = 1'b0;
      ckRise  = 1'b0;
      found   = 1'b0;
      pw      = '0;
      doAlign = 1'b0;
      next_s  = s;
      next_s.gpioS1  = gpioPin;
      next_s.gpioS2  = s.gpioS1;
      next_s.pinS1   = refPin;
      next_s.pinS2   = s.pinS1;
      next_s.pinPrev = s.pinS2;
      next_s.gpioDsq = gpioDsqNow;
      next_s.valid   = qualified & ~(freqAlarm & ~s.mask[`MASK_FREQ +: NUM_REFS])
                     & ~gpioDsqNow;
      next_s.oscSuspect = &(actAlarm | losAlarm | freqAlarm);
      // switchover when the active reference loses validity
      act = s.sel[`SEL_ACT +: 3];
      next_s.switchReq = 1'b0;
      if (s.valid[act] && !next_s.valid[act]) begin
         for (int i = NUM_REFS - 1; i >= 0; i--) begin
            if (next_s.valid[i] && 3'(i) != act) begin
               found = 1'b1;
               next_s.switchTarget = 3'(i);
            end
         end
         if (found) begin
            next_s.switchReq = 1'b1;
            next_s.sel[`SEL_ACT +: 3] = next_s.switchTarget;
         end
      end
      // frame or sync edge detection on synchronised pins
      frIdx  = s.sel[`SEL_FRAME +: 3];
      ckIdx  = s.sel[`SEL_CLK +: 3];
      frEdge = s.ctrl[`CTRL_FALL] ? (s.pinPrev[frIdx] && !s.pinS2[frIdx])
                                  : (!s.pinPrev[frIdx] && s.pinS2[frIdx]);
      ckRise = !s.pinPrev[ckIdx] && s.pinS2[ckIdx];
      case (s.alState)
         AL_IDLE: begin
            if (s.ctrl[`CTRL_EN] && frEdge) begin
               if (s.ctrl[`CTRL_SYNC]) begin
                  doAlign = 1'b1;
               end else begin
                  next_s.alState = AL_ARMED;
               end
            end
         end
         AL_ARMED: begin
            if (!s.ctrl[`CTRL_EN] || s.ctrl[`CTRL_SYNC]) begin
               next_s.alState = AL_IDLE;
            end else if (ckRise) begin
               doAlign        = 1'b1;
               next_s.alState = AL_IDLE;
            end
         end
         default: next_s.alState = AL_IDLE;
      endcase
      case (s.ctrl[`CTRL_PW +: 2])
         2'h0:    pw = 8'(PW0);
         2'h1:    pw = 8'(PW1);
         2'h2:    pw = 8'(PW2);
         default: pw = 8'(PW3);
      endcase
      // frame output and clock output, restarted on alignment
      next_s.alignPulse = doAlign;
      if (doAlign) begin
         next_s.frameCnt = '0;
         next_s.pwCnt    = pw - 8'h1;
         next_s.frameOut = 1'b1;
         next_s.clkCnt   = '0;
         next_s.clkOut   = 1'b1;
         next_s.alignCnt = s.alignCnt + 16'h1;
      end else begin
         if (s.frameCnt + 24'h1 >= s.framePer) begin
            next_s.frameCnt = '0;
            next_s.pwCnt    = pw - 8'h1;
            next_s.frameOut = 1'b1;
         end else begin
            next_s.frameCnt = s.frameCnt + 24'h1;
            if (s.pwCnt != 8'h0) begin
               next_s.pwCnt = s.pwCnt - 8'h1;
            end else begin
               next_s.frameOut = 1'b0;
            end
         end
         if (s.clkCnt + 16'h1 >= s.clkHalf) begin
            next_s.clkCnt = '0;
            next_s.clkOut = !s.clkOut;
         end else begin
            next_s.clkCnt = s.clkCnt + 16'h1;
         end
      end
      // register port
      next_s.readData = '0;
      if (writeStrobe) begin
         case (address)
            `REG_CTRL:  next_s.ctrl     = writeData;
            `REG_SEL:   next_s.sel      = writeData;
            `REG_TIMER: next_s.timer    = writeData;
            `REG_MASK:  next_s.mask     = writeData;
            `REG_GPIO:  next_s.gpioCfg  = writeData;
            `REG_FPER:  next_s.framePer = writeData[23:0];
            `REG_CHALF: next_s.clkHalf  = writeData[15:0];
            default:    next_s.readData = '0;
         endcase
      end
      if (readStrobe) begin
         case (address)
            `REG_CTRL:   next_s.readData = s.ctrl;
            `REG_SEL:    next_s.readData = s.sel;
            `REG_TIMER:  next_s.readData = s.timer;
            `REG_MASK:   next_s.readData = s.mask;
            `REG_GPIO:   next_s.readData = s.gpioCfg;
            `REG_FPER:   next_s.readData = {8'h0, s.framePer};
            `REG_CHALF:  next_s.readData = {16'h0, s.clkHalf};
            `REG_STATUS: next_s.readData = {7'h0, s.oscSuspect, 8'(s.gpioDsq),
                                            8'(qualified), 8'(s.valid)};
            `REG_ACNT:   next_s.readData = {16'h0, s.alignCnt};
            default:     next_s.readData = '0;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         s          <= '0;
         s.framePer <= `FPER_RST;
         s.clkHalf  <= `CHALF_RST;
         s.alState  <= AL_IDLE;
      end else begin
         s <= next_s;
      end
   end

   assign readData      = s.readData;
   assign refValid      = s.valid;
   assign switchReq     = s.switchReq;
   assign switchTarget  = s.switchTarget;
   assign oscRefSuspect = s.oscSuspect;
   assign alignPulse    = s.alignPulse;
   assign frameOut      = s.frameOut;
   assign clkOut        = s.clkOut;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   sequence frameArmed;
      s.alState == AL_ARMED && s.ctrl[`CTRL_EN] && !s.ctrl[`CTRL_SYNC];
   endsequence
   sequence clockRises;
      !s.pinPrev[s.sel[`SEL_CLK +: 3]] && s.pinS2[s.sel[`SEL_CLK +: 3]];
   endsequence

   a_gpio_blocks_valid: assert property (@(posedge mclk) disable iff (!reset_n)
      $past(s.gpioS2[0] && s.gpioCfg[`GPIO_EN]) |-> !refValid[$past(s.gpioCfg[2:0])])
      else $error("reference valid while its gpio disqualifies it");
   a_valid_needs_qual: assert property (@(posedge mclk) disable iff (!reset_n)
      $rose(refValid[0]) |-> $past(qualified[0]) && !$past(gpioDsqNow[0]))
      else $error("reference 0 valid without qualification");
   a_switch_target_ok: assert property (@(posedge mclk) disable iff (!reset_n)
      switchReq |-> refValid[switchTarget] && !refValid[$past(s.sel[`SEL_ACT +: 3])])
      else $error("switchover to an invalid reference");
   a_frame_align_edge: assert property (@(posedge mclk) disable iff (!reset_n)
      (frameArmed and clockRises) |=> alignPulse ##1 !alignPulse)
      else $error("armed frame missed the clock edge");
   a_sync_align_edge: assert property (@(posedge mclk) disable iff (!reset_n)
      alignPulse && $past(s.ctrl[`CTRL_SYNC], 2) && $past(s.ctrl[`CTRL_EN], 2)
      |-> $past(s.alState) == AL_IDLE)
      else $error("sync alignment not from the sync edge");
   a_align_restarts: assert property (@(posedge mclk) disable iff (!reset_n)
      alignPulse |-> frameOut && clkOut && s.frameCnt == 24'h0)
      else $error("alignment did not restart outputs");
   a_osc_suspect_all: assert property (@(posedge mclk) disable iff (!reset_n)
      oscRefSuspect |-> $past(&(actAlarm | losAlarm | freqAlarm)))
      else $error("oscillator flagged without all inputs failing");
   a_read_one_cycle: assert property (@(posedge mclk) disable iff (!reset_n)
      !$past(readStrobe) |-> readData == 32'h0)
      else $error("read data outside its cycle");
endmodule
`default_nettype wire

// ### test/ref_source_model.sv
// far side model: reference clock, frame or sync pulses and phy loss-of-signal pins
// assumes: the bench calls its tasks; all pins are asynchronous to mclk
`timescale 1ns/100ps
`default_nettype none
module ref_source_model #(
   parameter int CLK_IDX = 3
) (
   output logic [7:0] refPin,
   output logic [3:0] gpioPin
);
   // ----------------------------------------
   // associated clock
   // ----------------------------------------
   logic clkRun;
   initial begin
      refPin  = 8'h00;
      gpioPin = 4'h0;
      clkRun  = 1'b0;
   end
   // 640 ns period, an integer multiple of the 40 ns mclk period, far below the limits
   always begin
      #320;
      if (clkRun) refPin[CLK_IDX] = ~refPin[CLK_IDX];
      else refPin[CLK_IDX] = 1'b0;
   end
   // ----------------------------------------
   // pulse and loss-of-signal sources
   // ----------------------------------------
   task automatic runClk(input logic on);
      clkRun = on;
   endtask
   task automatic pulse(input int idx, input int widthNs);
      #7 refPin[idx] = 1'b1;
      #(widthNs) refPin[idx] = 1'b0;
   endtask
   task automatic frameAfterClk(input int idx, input int widthNs);
      @(posedge refPin[CLK_IDX]);
      #100 refPin[idx] = 1'b1;
      #(widthNs) refPin[idx] = 1'b0;
   endtask
   task automatic setLos(input int idx, input logic val);
      #13 gpioPin[idx] = val;
   endtask
endmodule
`default_nettype wire

// ### test/tb_ref_qualify_frame_sync_align.sv
// self-checking bench for reference qualification and frame or sync alignment
// assumes: design files under core/ compiled first; far side model in test/
`timescale 1ns/100ps
`default_nettype none
`include "ref_qualify_map.svh"
module tb_ref_qualify_frame_sync_align;
   import ref_qualify_pkg::*;
   // ----------------------------------------
   // signals and design
   // ----------------------------------------
   localparam int DSQ [4] = '{8, 4, 6, 10};
   localparam int MUL [4] = '{4, 2, 8, 16};
   typedef struct {
      logic [7:0] act;
      logic [7:0] los;
      logic [7:0] freq;
      word_t      mask;
      int         hold;
      logic [7:0] exp;
   } row_t;
   row_t rows [7] = '{'{8'h00, 8'h00, 8'h01, 32'h00000000, 3, 8'hfe},
                      '{8'h00, 8'h00, 8'h01, 32'h00010000, 3, 8'hff},
                      '{8'h02, 8'h00, 8'h00, 32'h00000000, 2, 8'hff},
                      '{8'h02, 8'h00, 8'h00, 32'h00000000, 8, 8'hfd},
                      '{8'h00, 8'h80, 8'h00, 32'h00000000, 8, 8'h7f},
                      '{8'h00, 8'h80, 8'h00, 32'h00008000, 8, 8'hff},
                      '{8'h08, 8'h00, 8'h00, 32'h00000008, 8, 8'hff}};
   logic        mclk = 1'b0;
   logic        reset_n = 1'b0;
   logic [3:0]  address = 4'h0;
   word_t       writeData = 32'h0;
   logic        writeStrobe = 1'b0;
   logic        readStrobe = 1'b0;
   word_t       readData;
   logic [7:0]  actAlarm = 8'h00;
   logic [7:0]  losAlarm = 8'h00;
   logic [7:0]  freqAlarm = 8'h00;
   wire  [3:0]  gpioPin;
   wire  [7:0]  refPin;
   logic [7:0]  refValid;
   logic        switchReq;
   logic [2:0]  switchTarget;
   logic        oscRefSuspect;
   logic        alignPulse;
   logic        frameOut;
   logic        clkOut;
   int          nErrors = 0;
   int          cmpCount = 0;
   int          nSwitch = 0;
   int          n;
   int          w;
   int          k;
   word_t       d;
   always #20 mclk = ~mclk;
   ref_qualify_frame_sync_align #(.DSQ_CYC0(DSQ[0]), .DSQ_CYC1(DSQ[1]), .DSQ_CYC2(DSQ[2]),
                                  .DSQ_CYC3(DSQ[3])) i_dut (
      .mclk(mclk), .reset_n(reset_n), .address(address), .writeData(writeData),
      .writeStrobe(writeStrobe), .readStrobe(readStrobe), .readData(readData),
      .actAlarm(actAlarm), .losAlarm(losAlarm), .freqAlarm(freqAlarm), .gpioPin(gpioPin),
      .refPin(refPin), .refValid(refValid), .switchReq(switchReq),
      .switchTarget(switchTarget), .oscRefSuspect(oscRefSuspect), .alignPulse(alignPulse),
      .frameOut(frameOut), .clkOut(clkOut));
   ref_source_model i_src (.refPin(refPin), .gpioPin(gpioPin));
   always @(posedge mclk) if (switchReq === 1'b1) nSwitch++;
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic closeOut();
      if (nErrors == 0 && cmpCount > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic chkW(input string name, input word_t exp, input word_t got);
      cmpCount++;
      if (got !== exp) begin
         nErrors++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic chkI(input string name, input int exp, input int got);
      cmpCount++;
      if (got != exp) begin
         nErrors++;
         $display("[ERR] %s expected %0d seen %0d", name, exp, got);
      end
   endtask
   task automatic wr(input logic [3:0] a, input word_t v);
      @(posedge mclk);
      address <= a;
      writeData <= v;
      writeStrobe <= 1'b1;
      @(posedge mclk);
      writeStrobe <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output word_t v);
      @(posedge mclk);
      address <= a;
      readStrobe <= 1'b1;
      @(posedge mclk);
      readStrobe <= 1'b0;
      #1 v = readData;
   endtask
   task automatic waitAlign(input int lim, output int cnt);
      cnt = -1;
      for (int i = 1; i <= lim; i++) begin
         @(posedge mclk);
         #1;
         if (alignPulse === 1'b1) begin
            cnt = i;
            break;
         end
      end
   endtask
   initial begin
      #(`MCLK_NS * 30000);
      nErrors++;
      closeOut();
   end
   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial begin
      repeat (19) @(posedge mclk);
      #1 chkW("outputs in reset", {refValid, switchReq, switchTarget, oscRefSuspect,
                                   alignPulse, frameOut, clkOut}, 0);
      chkW("read data in reset", readData, 0);
      @(posedge mclk);
      reset_n <= 1'b1;
      repeat (10) @(posedge mclk);
      #1 chkW("valid before qualify", refValid, 0);
      rd(`REG_FPER, d);
      chkW("frame period reset", d, `FPER_RST);
      @(posedge mclk);
      #1 chkW("read data after one cycle", readData, 0);
      rd(`REG_CHALF, d);
      chkW("half period reset", d, `CHALF_RST);
      rd(4'hf, d);
      chkW("unmapped read", d, 0);
      repeat (40) @(posedge mclk);
      rd(`REG_STATUS, d);
      chkW("status valid and qualified", d & 32'hffff, 32'hffff);
      for (int t = 0; t < 4; t++) begin
         wr(`REG_TIMER, t | (t << 2));
         @(posedge mclk);
         actAlarm <= 8'h01;
         n = 0;
         while (refValid[0] !== 1'b0 && n < 400) begin @(posedge mclk); #1; n++; end
         chkI("disqualify time", 1, n >= DSQ[t] && n <= DSQ[t] + 3);
         @(posedge mclk);
         actAlarm <= 8'h00;
         n = 0;
         while (refValid[0] !== 1'b1 && n < 400) begin @(posedge mclk); #1; n++; end
         chkI("qualify time", 1, n >= DSQ[t] * MUL[t] && n <= DSQ[t] * MUL[t] + 3);
      end
      wr(`REG_TIMER, 32'h5);
      foreach (rows[r]) begin
         wr(`REG_MASK, rows[r].mask);
         @(posedge mclk);
         actAlarm <= rows[r].act;
         losAlarm <= rows[r].los;
         freqAlarm <= rows[r].freq;
         repeat (rows[r].hold) @(posedge mclk);
         #1 chkW("valid under alarms", refValid, rows[r].exp);
         @(posedge mclk);
         {actAlarm, losAlarm, freqAlarm} <= 24'h000000;
         repeat (20) @(posedge mclk);
      end
      chkI("switches so far", 2, nSwitch);
      wr(`REG_MASK, 32'h0);
      wr(`REG_GPIO, 32'h85000082);
      rd(`REG_GPIO, d);
      chkW("gpio map readback", d, 32'h85000082);
      wr(`REG_SEL, 32'h00000200);
      i_src.setLos(0, 1'b1);
      @(posedge mclk);
      #1 chkW("gpio not yet seen", refValid[2], 1);
      repeat (4) @(posedge mclk);
      #1 chkW("gpio disqualifies", refValid, 8'hfb);
      chkI("switch on active loss", 3, nSwitch);
      chkW("switch target", switchTarget, 0);
      rd(`REG_SEL, d);
      chkW("active ref rewritten", d, 0);
      i_src.setLos(3, 1'b1);
      repeat (5) @(posedge mclk);
      #1 chkW("second gpio target", refValid, 8'hdb);
      chkI("no switch for idle ref", 3, nSwitch);
      i_src.setLos(0, 1'b0);
      i_src.setLos(3, 1'b0);
      @(posedge mclk);
      freqAlarm <= 8'hfe;
      repeat (4) @(posedge mclk);
      #1 chkW("one ref still clean", oscRefSuspect, 0);
      @(posedge mclk);
      freqAlarm <= 8'hff;
      repeat (4) @(posedge mclk);
      #1 chkW("all refs failing", oscRefSuspect, 1);
      chkI("no switch without target", 3, nSwitch);
      @(posedge mclk);
      freqAlarm <= 8'h00;
      wr(`REG_FPER, 32'h00000028);
      wr(`REG_SEL, 32'h00000034);
      for (int p = 0; p < 4; p++) begin
         wr(`REG_CTRL, 32'h3 | (p << 4));
         fork i_src.pulse(4, 120); join_none
         @(posedge refPin[4]);
         waitAlign(12, n);
         chkI("sync latency", 1, n >= 1 && n <= 6);
         chkW("clock restarts", clkOut, 1);
         w = 0;
         while (frameOut === 1'b1 && w < 20) begin w++; @(posedge mclk); #1; end
         chkI("frame width", 1 << p, w);
         k = w;
         while (frameOut !== 1'b1 && k < 100) begin k++; @(posedge mclk); #1; end
         chkI("frame period", 40, k);
      end
      rd(`REG_ACNT, d);
      chkW("alignment count", d & 32'hffff, 4);
      wr(`REG_CTRL, 32'h7);
      fork i_src.pulse(4, 400); join_none
      @(posedge refPin[4]);
      waitAlign(25, n);
      chkI("sync falling edge", 1, n >= 11 && n <= 17);
      wr(`REG_CTRL, 32'h2);
      fork i_src.pulse(4, 120); join_none
      @(posedge refPin[4]);
      waitAlign(15, n);
      chkI("disabled ignores edge", -1, n);
      i_src.runClk(1'b1);
      for (int f = 0; f < 2; f++) begin
         wr(`REG_CTRL, 32'h1 | (f << 2));
         fork i_src.frameAfterClk(4, 120 + 480 * f); join_none
         @(posedge refPin[4]);
         waitAlign(40, n);
         k = 16 * f;
         chkI("frame waits for clock edge", 1, n >= 10 + k && n <= 20 + k);
      end
      i_src.runClk(1'b0);
      closeOut();
   end
endmodule
`default_nettype wire
